/* hw/sfd_flash_cmd.v */
// Serial flash command logic: dual-output array read and byte/page program
`include "sfd_regs.vh"
`default_nettype none

module sfd_flash_cmd #(
    parameter [19:0] PP_CYCLES = `SFD_PP_CYCLES
) (
    input  wire        CLK,
    input  wire        SRST,
    input  wire        CHIP_SEL_N,
    input  wire        SER_CLK,
    input  wire        SER_IN,
    output reg         SER_OUT,
    output reg         SER_OUT_OE,
    output reg         AUX_DATA_PIN_OUT,
    output reg         AUX_DATA_PIN_OE,
    input  wire        WRITE_ENABLE_LATCH,
    output reg         WRITE_ENABLE_LATCH_CLR,
    output reg         BUSY,
    output reg         ERASE_PROGRAM_ERROR_SET,
    output reg  [23:0] START_ADDRESS,
    input  wire        SECTOR_PROT,
    output reg  [22:0] ARRAY_ADDR,
    output reg         ARRAY_RD,
    input  wire [7:0]  ARRAY_RD_DATA,
    output reg         ARRAY_WR,
    output reg  [7:0]  ARRAY_WR_DATA
);

    localparam [19:0] BP_CYCLES = `SFD_BP_CYCLES;

    // Frame states
    localparam [2:0] F_CMD   = 3'h0;
    localparam [2:0] F_ADDR  = 3'h1;
    localparam [2:0] F_DUMMY = 3'h2;
    localparam [2:0] F_READ  = 3'h3;
    localparam [2:0] F_PROG  = 3'h4;
    localparam [2:0] F_SKIP  = 3'h5;

    // Program engine states
    localparam [2:0] P_IDLE   = 3'h0;
    localparam [2:0] P_SCAN   = 3'h1;
    localparam [2:0] P_RDBUF  = 3'h2;
    localparam [2:0] P_VERIFY = 3'h3;
    localparam [2:0] P_RDWAIT = 3'h4;
    localparam [2:0] P_CMP    = 3'h5;
    localparam [2:0] P_WAIT   = 3'h6;

    wire [2:0]   pin_s;
    wire         cs_n_s;
    wire         sck_s;
    wire         si_s;
    reg          sck_prev_q;
    reg          cs_prev_q;
    wire         sck_rise;
    wire         sck_fall;
    wire         cs_rise;
    reg  [2:0]   frame_q;
    reg  [2:0]   bit_q;
    reg  [6:0]   sh_q;
    reg  [1:0]   acnt_q;
    reg          is_read_q;
    wire         byte_done;
    wire [7:0]   full_byte;
    wire [23:0]  addr_full;
    reg  [8:0]   dcnt_q;
    reg  [255:0] vld_q;
    wire         buf_we;
    wire [7:0]   buf_waddr;
    wire [7:0]   buf_rdata;
    reg  [22:0]  rd_addr_q;
    reg          rd_pend_q;
    reg  [7:0]   nxt_q;
    reg  [7:0]   out_sh_q;
    reg  [1:0]   pair_q;
    wire         rd_issue_first;
    wire         rd_issue_next;
    reg  [2:0]   pst_q;
    reg  [8:0]   idx_q;
    reg  [19:0]  tmr_q;
    reg  [7:0]   wdat_q;
    wire         prog_ok;

    // Pin synchronisers
    sfd_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk  (CLK),
        .srst (SRST),
        .din  ({CHIP_SEL_N, SER_CLK, SER_IN}),
        .dout (pin_s)
    );

    assign cs_n_s = pin_s[2];
    assign sck_s  = pin_s[1];
    assign si_s   = pin_s[0];

    // Serial clock and select edge detection
    always @(posedge CLK) begin
        if (SRST) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_n_s;
        end
    end

    assign sck_rise  = ~cs_n_s & sck_s & ~sck_prev_q;
    assign sck_fall  = ~cs_n_s & ~sck_s & sck_prev_q;
    assign cs_rise   = cs_n_s & ~cs_prev_q;
    assign byte_done = sck_rise & (bit_q == 3'h7);
    assign full_byte = {sh_q, si_s};
    assign addr_full = {START_ADDRESS[15:0], full_byte};

    // Command, address and dummy byte decoding
    always @(posedge CLK) begin
        if (SRST | cs_n_s) begin
            frame_q <= F_CMD;
            bit_q   <= 3'h0;
            sh_q    <= 7'h00;
            acnt_q  <= 2'h0;
        end else if (sck_rise) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= full_byte[6:0];
            if (byte_done) begin
                case (frame_q)
                    F_CMD: begin
                        if (BUSY) begin
                            frame_q <= F_SKIP;
                        end else if (full_byte == `SFD_OP_DUAL_READ) begin
                            frame_q <= F_ADDR;
                        end else if (full_byte == `SFD_OP_PAGE_PROG &&
                                     WRITE_ENABLE_LATCH) begin
                            frame_q <= F_ADDR;
                        end else begin
                            frame_q <= F_SKIP;
                        end
                    end
                    F_ADDR: begin
                        acnt_q <= acnt_q + 2'h1;
                        if (acnt_q == `SFD_ADDR_BYTES - 2'h1) begin
                            frame_q <= is_read_q ? F_DUMMY : F_PROG;
                        end
                    end
                    F_DUMMY: frame_q <= F_READ;
                    default: frame_q <= frame_q;
                endcase
            end
        end
    end

    // Command kind and start address, kept after select rises
    always @(posedge CLK) begin
        if (SRST) begin
            is_read_q     <= 1'b0;
            START_ADDRESS <= 24'h000000;
        end else if (byte_done && frame_q == F_CMD) begin
            is_read_q <= (full_byte == `SFD_OP_DUAL_READ);
        end else if (byte_done && frame_q == F_ADDR) begin
            START_ADDRESS <= addr_full;
        end
    end

    // Page buffer loading with in-page wrap
    assign buf_we    = byte_done & (frame_q == F_PROG);
    assign buf_waddr = START_ADDRESS[7:0] + dcnt_q[7:0];

    always @(posedge CLK) begin
        if (SRST) begin
            dcnt_q <= 9'h000;
            vld_q  <= 256'h0;
        end else if (byte_done && frame_q == F_ADDR && !is_read_q &&
                     acnt_q == `SFD_ADDR_BYTES - 2'h1) begin
            dcnt_q <= 9'h000;
            vld_q  <= 256'h0;
        end else if (buf_we) begin
            // Low byte keeps wrapping through the page; top bit remembers a full page
            dcnt_q <= {dcnt_q[8] | (dcnt_q[7:0] == 8'hff), dcnt_q[7:0] + 8'h01};
            vld_q[buf_waddr] <= 1'b1;
        end
    end

    sfd_page_buf u_buf (
        .clk   (CLK),
        .we    (buf_we),
        .waddr (buf_waddr),
        .wdata (full_byte),
        .raddr (idx_q[7:0]),
        .rdata (buf_rdata)
    );

    // Read prefetch requests: first at the dummy byte, then one per byte output
    assign rd_issue_first = byte_done & (frame_q == F_DUMMY);
    assign rd_issue_next  = sck_fall & (frame_q == F_READ) & (pair_q == 2'h0);

    always @(posedge CLK) begin
        if (SRST) begin
            rd_addr_q <= 23'h000000;
            rd_pend_q <= 1'b0;
            nxt_q     <= `SFD_ERASED_BYTE;
        end else begin
            rd_pend_q <= ARRAY_RD & (pst_q == P_IDLE);
            if (rd_issue_first) begin
                rd_addr_q <= START_ADDRESS[22:0] + 23'h000001;
            end else if (rd_issue_next) begin
                rd_addr_q <= rd_addr_q + 23'h000001;
            end
            if (rd_pend_q) begin
                nxt_q <= ARRAY_RD_DATA;
            end
        end
    end

    // Dual output shifter, updated after falling serial clock edges
    always @(posedge CLK) begin
        if (SRST | cs_n_s) begin
            SER_OUT_OE       <= 1'b0;
            AUX_DATA_PIN_OE  <= 1'b0;
            SER_OUT          <= 1'b0;
            AUX_DATA_PIN_OUT <= 1'b0;
            out_sh_q         <= 8'h00;
            pair_q           <= 2'h0;
        end else if (sck_fall && frame_q == F_READ) begin
            SER_OUT_OE      <= 1'b1;
            AUX_DATA_PIN_OE <= 1'b1;
            pair_q          <= pair_q + 2'h1;
            if (pair_q == 2'h0) begin
                SER_OUT          <= nxt_q[7];
                AUX_DATA_PIN_OUT <= nxt_q[6];
                out_sh_q         <= {nxt_q[5:0], 2'b00};
            end else begin
                SER_OUT          <= out_sh_q[7];
                AUX_DATA_PIN_OUT <= out_sh_q[6];
                out_sh_q         <= {out_sh_q[5:0], 2'b00};
            end
        end
    end

    // Program accepted only with full address, whole bytes and unprotected start
    assign prog_ok = (frame_q == F_PROG) && (dcnt_q != 9'h000) &&
                     (bit_q == 3'h0) && !SECTOR_PROT;

    // Self-timed program engine with per-byte verify
    always @(posedge CLK) begin
        if (SRST) begin
            pst_q                   <= P_IDLE;
            idx_q                   <= 9'h000;
            tmr_q                   <= 20'h00000;
            wdat_q                  <= 8'h00;
            BUSY                    <= 1'b0;
            WRITE_ENABLE_LATCH_CLR  <= 1'b0;
            ERASE_PROGRAM_ERROR_SET <= 1'b0;
            ARRAY_ADDR              <= 23'h000000;
            ARRAY_RD                <= 1'b0;
            ARRAY_WR                <= 1'b0;
            ARRAY_WR_DATA           <= 8'h00;
        end else begin
            WRITE_ENABLE_LATCH_CLR  <= 1'b0;
            ERASE_PROGRAM_ERROR_SET <= 1'b0;
            ARRAY_RD                <= 1'b0;
            ARRAY_WR                <= 1'b0;
            if (tmr_q != 20'h00000) begin
                tmr_q <= tmr_q - 20'h00001;
            end
            case (pst_q)
                P_IDLE: begin
                    if (rd_issue_first) begin
                        ARRAY_ADDR <= START_ADDRESS[22:0];
                        ARRAY_RD   <= 1'b1;
                    end else if (rd_issue_next) begin
                        ARRAY_ADDR <= rd_addr_q;
                        ARRAY_RD   <= 1'b1;
                    end
                    if (cs_rise && !is_read_q &&
                        (frame_q == F_ADDR || frame_q == F_PROG)) begin
                        WRITE_ENABLE_LATCH_CLR <= 1'b1;
                        if (prog_ok) begin
                            BUSY  <= 1'b1;
                            idx_q <= 9'h000;
                            pst_q <= P_SCAN;
                            tmr_q <= (dcnt_q == 9'h001) ? BP_CYCLES : PP_CYCLES;
                        end
                    end
                end
                P_SCAN: begin
                    if (idx_q == `SFD_PAGE_BYTES) begin
                        pst_q <= P_WAIT;
                    end else if (vld_q[idx_q[7:0]]) begin
                        pst_q <= P_RDBUF;
                    end else begin
                        idx_q <= idx_q + 9'h001;
                    end
                end
                P_RDBUF: begin
                    ARRAY_ADDR    <= {START_ADDRESS[22:8], idx_q[7:0]};
                    ARRAY_WR      <= 1'b1;
                    ARRAY_WR_DATA <= buf_rdata;
                    wdat_q        <= buf_rdata;
                    pst_q         <= P_VERIFY;
                end
                P_VERIFY: begin
                    ARRAY_RD <= 1'b1;
                    pst_q    <= P_RDWAIT;
                end
                P_RDWAIT: pst_q <= P_CMP;
                P_CMP: begin
                    if (ARRAY_RD_DATA != wdat_q) begin
                        ERASE_PROGRAM_ERROR_SET <= 1'b1;
                    end
                    idx_q <= idx_q + 9'h001;
                    pst_q <= P_SCAN;
                end
                P_WAIT: begin
                    if (tmr_q == 20'h00000) begin
                        BUSY  <= 1'b0;
                        pst_q <= P_IDLE;
                    end
                end
                default: pst_q <= P_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

/* hw/sfd_page_buf.v */
// Page buffer memory, 256 bytes, one write port and a registered read port
`default_nettype none

module sfd_page_buf (
    input  wire       clk,
    input  wire       we,
    input  wire [7:0] waddr,
    input  wire [7:0] wdata,
    input  wire [7:0] raddr,
    output reg  [7:0] rdata
);

    reg [7:0] mem [0:255];

    // Write and registered read
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule
`default_nettype wire

/* hw/sfd_regs.vh */
// Constants for the serial flash dual-output read and byte/page program command block
//
// What this block does
// - Read data leaves two bits per clock, bit 7 on output pin, bit 6 aux.
// - Each data byte takes four clocks; address counter advances while clocks continue.
// - Reading past 7FFFFFh continues at 000000h without any extra delay.
// - Raising select at any moment ends the read and floats both data pins.
// - Program is opcode 02h, three address bytes, then data into page buffer.
// - Data running past the page end wraps to the start of that page.
// - Beyond 256 data bytes only the last 256 received are kept.
// - On select release buffered bytes are programmed; unsent page bytes stay FFh.
// - Programming is self-timed: page program time, or byte program time for one byte.
// - Abort if address or first data byte incomplete, or bits not byte aligned.
// - Protected or locked start address skips programming, back to idle on release.
// - Every program abort clears the write enable latch.
// - While programming, status shows busy; host should poll rather than wait.
// - Write enable latch clears before a successful program cycle ends.
// - Each programmed byte is verified; a mismatch sets the erase/program error flag.
`ifndef SFD_REGS_VH
`define SFD_REGS_VH

// Opcodes
`define SFD_OP_DUAL_READ 8'h3b
`define SFD_OP_PAGE_PROG 8'h02

// Array and page geometry
`define SFD_ERASED_BYTE  8'hff
`define SFD_ADDR_BYTES   2'h3
`define SFD_PAGE_BYTES   9'h100

// Timing: program times in 50 MHz system clock cycles, sized for the 20-bit timer
`define SFD_PP_CYCLES    20'hc350
`define SFD_BP_CYCLES    20'h0015e

`endif

/* hw/sfd_sync.v */
// Two-flop synchroniser for pins from outside the system clock domain
`default_nettype none

module sfd_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (srst) begin
            meta_q <= {WIDTH{1'b1}};
            dout   <= {WIDTH{1'b1}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* verification/sfd_flash_cmd_asserts.sv */
// Port checker for the flash command block
`default_nettype none
module sfd_chk (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        CHIP_SEL_N,
    input wire logic        SER_OUT_OE,
    input wire logic        AUX_DATA_PIN_OE,
    input wire logic        WRITE_ENABLE_LATCH_CLR,
    input wire logic        BUSY,
    input wire logic        ERASE_PROGRAM_ERROR_SET,
    input wire logic [23:0] START_ADDRESS,
    input wire logic        SECTOR_PROT,
    input wire logic [22:0] ARRAY_ADDR,
    input wire logic        ARRAY_RD,
    input wire logic        ARRAY_WR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // Pin drive, start and program sequencing
    a_oe_float: assert property (
        CHIP_SEL_N [*5] |-> !SER_OUT_OE && !AUX_DATA_PIN_OE)
        else $error("Data pins driven while deselected");
    a_oe_pair: assert property (
        SER_OUT_OE == AUX_DATA_PIN_OE) else $error("Data pin enables differ");
    a_start_clr: assert property (
        $rose(BUSY) |-> WRITE_ENABLE_LATCH_CLR && CHIP_SEL_N)
        else $error("Program start without latch clear");
    a_prot_skip: assert property (
        $rose(BUSY) |-> !$past(SECTOR_PROT)) else $error("Protected page programmed");
    a_clr_pulse: assert property (
        $rose(WRITE_ENABLE_LATCH_CLR) |-> CHIP_SEL_N ##1 !WRITE_ENABLE_LATCH_CLR)
        else $error("Latch clear not a single pulse after release");
    a_wr_busy: assert property (
        ARRAY_WR |-> BUSY && !SER_OUT_OE) else $error("Array write outside busy");
    a_wr_page: assert property (
        ARRAY_WR |-> ARRAY_ADDR[22:8] == START_ADDRESS[22:8])
        else $error("Array write outside start page");
    a_wr_verify: assert property (
        ARRAY_WR |=> ARRAY_RD && $stable(ARRAY_ADDR)) else $error("Write not read back");
    a_err_cause: assert property (
        ERASE_PROGRAM_ERROR_SET |-> BUSY && $past(ARRAY_RD, 2))
        else $error("Error flag without verify read");
endmodule
bind sfd_flash_cmd sfd_chk u_chk (.CLK(CLK), .SRST(SRST), .CHIP_SEL_N(CHIP_SEL_N),
    .SER_OUT_OE(SER_OUT_OE), .AUX_DATA_PIN_OE(AUX_DATA_PIN_OE),
    .WRITE_ENABLE_LATCH_CLR(WRITE_ENABLE_LATCH_CLR), .BUSY(BUSY),
    .ERASE_PROGRAM_ERROR_SET(ERASE_PROGRAM_ERROR_SET), .START_ADDRESS(START_ADDRESS),
    .SECTOR_PROT(SECTOR_PROT), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_RD(ARRAY_RD),
    .ARRAY_WR(ARRAY_WR));
`default_nettype wire

/* verification/sfd_host.sv */
// Host controller model driving select, serial clock and serial data in mode 0
`default_nettype none
module sfd_host (
    input  wire logic clk,
    output var  logic cs_n,
    output var  logic sck,
    output var  logic sdi,
    input  wire logic so,
    input  wire logic aux
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       txq [$];
    logic [1:0] rxq [$];
    // Idle pins: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // One frame; any bit count, so partial bytes can be sent on purpose
    task automatic frame();
        logic b;
        @(negedge clk) cs_n = 1'b0;
        repeat (4) @(negedge clk);
        while (txq.size() > 0) begin
            b = txq.pop_front();
            sdi = b;
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            rxq.push_back({so, aux}); // Read just before the fall, where pins are settled
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        sdi = ~sdi; // Released line shows no stale value
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Testbench: host model, array and latch models, write scoreboard
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        prot = 1'b0;
    logic        write_enable_latch = 1'b0;
    logic        fault = 1'b0;
    logic [7:0]  rdat = 8'h00;
    wire         cs_n, sck, sdi, so_o, so_oe, aux_o, aux_oe, clr, busy, erase_program_error, a_rd, a_wr;
    wire  [23:0] st_addr;
    wire  [22:0] a_addr;
    wire  [7:0]  wdat;
    logic [7:0]  mem [int];
    logic [31:0] wq [$];
    int          n_fail = 0;
    int          comparisons = 0;
    int          clr_n = 0;
    int          epe_n = 0;
    int          blen = 0;
    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    sfd_flash_cmd #(.PP_CYCLES(20'h007d0)) dut (.CLK(clk), .SRST(srst), .CHIP_SEL_N(cs_n),
        .SER_CLK(sck), .SER_IN(sdi), .SER_OUT(so_o), .SER_OUT_OE(so_oe),
        .AUX_DATA_PIN_OUT(aux_o), .AUX_DATA_PIN_OE(aux_oe), .WRITE_ENABLE_LATCH(write_enable_latch),
        .WRITE_ENABLE_LATCH_CLR(clr), .BUSY(busy), .ERASE_PROGRAM_ERROR_SET(erase_program_error),
        .START_ADDRESS(st_addr), .SECTOR_PROT(prot), .ARRAY_ADDR(a_addr), .ARRAY_RD(a_rd),
        .ARRAY_RD_DATA(rdat), .ARRAY_WR(a_wr), .ARRAY_WR_DATA(wdat));
    sfd_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .so(so_oe ? so_o : 1'bz), .aux(aux_oe ? aux_o : 1'bz));
    // Array model, latch model, event counters and write scoreboard
    always @(posedge clk) begin
        if (a_wr === 1'b1) mem[a_addr] = wdat;
        if (a_rd === 1'b1) rdat <= (mem.exists(a_addr) ? mem[a_addr] : 8'hff) ^ {8{fault}};
        if (clr === 1'b1) write_enable_latch <= 1'b0;
        if (clr === 1'b1) clr_n++;
        if (erase_program_error === 1'b1) epe_n++;
        if (busy === 1'b1) blen++;
        if (a_wr === 1'b1 && wq.size() == 0) fail("unexpected array write");
        else if (a_wr === 1'b1) chk({1'b0, a_addr, wdat}, wq.pop_front());
    end
    task automatic fail(input string m);
        n_fail++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) fail($sformatf("got %h want %h", g, e));
    endtask
    task automatic push(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) host.txq.push_back(v[i]);
    endtask
    // Poll busy instead of waiting the worst case
    task automatic settle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 3000) fail("busy stuck");
        if (k >= 3000) report_and_stop();
    endtask
    // Dual read: data pairs follow the 40 command bits, then a partial byte
    task automatic rd(input logic [22:0] a, input int nb);
        logic [7:0] e;
        for (int i = 0; i < nb; i++) mem[(a + i) & 23'h7fffff] = $urandom;
        host.rxq.delete();
        push(8'h3b, 8);
        push({1'b0, a}, 24);
        push($urandom, nb * 4 + 10);
        host.frame();
        chk(host.rxq[39], 2'bzz);
        for (int j = 0; j < nb * 4; j++) begin
            e = mem[(a + j / 4) & 23'h7fffff];
            chk(host.rxq[40 + j], {e[7 - 2 * (j % 4)], e[6 - 2 * (j % 4)]});
        end
        chk({so_oe, aux_oe}, 0);
    endtask
    // Program nb bytes; expected writes are the page slots in ascending order
    task automatic prog(input logic [23:0] a, input int nb, input logic f);
        logic [7:0] bd [256];
        logic       bv [256];
        logic [7:0] s;
        logic [7:0] d;
        int         c0;
        int         e0;
        int         x;
        for (int i = 0; i < 256; i++) bv[i] = 1'b0;
        write_enable_latch = 1'b1;
        fault = f;
        push(8'h02, 8);
        push(a, 24);
        for (int i = 0; i < nb; i++) begin
            s = a[7:0] + i[7:0];
            d = $urandom;
            bd[s] = d;
            bv[s] = 1'b1;
            push(d, 8);
        end
        for (int i = 0; i < 256; i++) begin
            if (bv[i]) wq.push_back({1'b0, a[22:8], i[7:0], bd[i]});
        end
        c0 = clr_n;
        e0 = epe_n;
        blen = 0;
        host.frame();
        settle();
        fault = 1'b0;
        x = (nb == 1) ? 350 : 2000;
        chk(st_addr, a);
        chk(clr_n - c0, 1);
        chk(write_enable_latch, 0);
        chk(blen >= x - 1 && blen <= x + 2, 1);
        chk(epe_n - e0, f ? ((nb > 256) ? 256 : nb) : 0);
        chk(wq.size(), 0);
    endtask
    // Program frames that must not start: bad bit counts, protection, latch low
    task automatic abort(input int nbits, input logic p, input logic w);
        int c0;
        write_enable_latch = w;
        prot = p;
        c0 = clr_n;
        blen = 0;
        push(8'h02, 8);
        push(24'h000300, (nbits > 24) ? 24 : nbits);
        if (nbits > 24) push($urandom, nbits - 24);
        host.frame();
        repeat (8) @(negedge clk);
        prot = 1'b0;
        chk(clr_n - c0, w);
        chk(blen, 0);
        chk(write_enable_latch, 0);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        int seed;
        seed = $urandom(1454);
        repeat (12) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        rd(23'h7ffffe, 3);
        prog(24'h0000fe, 3, 1'b0);
        prog(24'h012300, 258, 1'b0);
        prog(24'h040055, 1, 1'b1);
        abort(16, 1'b0, 1'b1);
        abort(28, 1'b0, 1'b1);
        abort(44, 1'b0, 1'b1);
        abort(32, 1'b1, 1'b1);
        abort(32, 1'b0, 1'b0);
        @(negedge clk) srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        rd(23'h012344, 2);
        report_and_stop();
    end
endmodule
`default_nettype wire
